// ===== hw/srb_defines.svh
`ifndef SRB_DEFINES_SVH
`define SRB_DEFINES_SVH

// Command opcodes.
`define SRB_OP_XFER_BUF1 8'h53
`define SRB_OP_XFER_BUF2 8'h55
`define SRB_OP_CMP_BUF1 8'h60
`define SRB_OP_CMP_BUF2 8'h61
`define SRB_OP_RESUME 8'hd0
`define SRB_OP_SUSPEND 8'hb0
`define SRB_OP_STATUS 8'hd7

// Status byte fields.
`define SRB_ST_READY_BIT 7
`define SRB_ST_CMP_BIT 6
`define SRB_ST_ES_BIT 2
`define SRB_ST_PS2_BIT 1
`define SRB_ST_PS1_BIT 0

// Internal operation times in ns and their cycle counts at 4 ns.
`define SRB_CLK_NS 4
`define SRB_RESUME_LATENCY_NS 400
`define SRB_COPY_TIME_NS 800
`define SRB_COMPARE_TIME_NS 800
`define SRB_PROGRAM_TIME_NS 4000
`define SRB_ERASE_TIME_NS 8000
`define SRB_RESUME_CYC (`SRB_RESUME_LATENCY_NS / `SRB_CLK_NS)
`define SRB_COPY_CYC (`SRB_COPY_TIME_NS / `SRB_CLK_NS)
`define SRB_COMPARE_CYC (`SRB_COMPARE_TIME_NS / `SRB_CLK_NS)
`define SRB_PROGRAM_CYC (`SRB_PROGRAM_TIME_NS / `SRB_CLK_NS)
`define SRB_ERASE_CYC (`SRB_ERASE_TIME_NS / `SRB_CLK_NS)

// Host serial clock: half period in pclk cycles (160 ns period).
`define SRB_SCK_HALF_CYC 20

// Host APB register offsets and reset values.
`define SRB_REG_CMD 12'h000
`define SRB_REG_ADDR 12'h004
`define SRB_REG_STAT 12'h008
`define SRB_REG_INT_STATUS 12'h00c
`define SRB_REG_INT_MASK 12'h010
`define SRB_INT_DONE_BIT 0
`define SRB_INT_MASK_RST 32'h0000_0000

`endif

// ===== hw/srb_pkg.sv
package srb_pkg;
    typedef enum logic [2:0] {
        DEV_IDLE,
        DEV_PROG,
        DEV_ERASE,
        DEV_RESUMING,
        DEV_XFER,
        DEV_CMP
    } srb_dev_state_e;

    typedef enum logic [1:0] {
        HST_IDLE,
        HST_SETUP,
        HST_SHIFT,
        HST_GAP
    } srb_host_state_e;

    typedef logic [15:0] srb_cnt_t;
endpackage

// ===== hw/srb_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface srb_link_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so;

    modport dev (input cs_n, input sck, input si, output so);
    modport host (output cs_n, output sck, output si, input so);
endinterface
`default_nettype wire

// ===== hw/srb_dev.sv
`timescale 1ns/1ps
`default_nettype none
`include "srb_defines.svh"

module srb_dev (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Serial link.
    srb_link_if.dev link,
    // Array side.
    input wire logic prog_start,
    input wire logic prog_buf,
    input wire logic erase_start,
    input wire logic page_differs,
    output logic [23:0] page_addr,
    output logic sel_buf,
    output logic xfer_go,
    output logic cmp_go,
    output logic busy,
    output logic [7:0] status
);
    logic [1:0] cs_sync_r, sck_sync_r, si_sync_r;
    logic cs_d_r, sck_d_r;
    logic [31:0] shift_r;
    logic [5:0] nbits_r;
    logic [7:0] out_r;
    srb_pkg::srb_dev_state_e state_r;
    srb_pkg::srb_cnt_t cnt_r, prog_left_r, erase_left_r;
    logic ps1_r, ps2_r, es_r, prog_buf_r, res_prog_r, cmp_fail_r;
    logic [23:0] page_addr_r;
    logic sel_buf_r, xfer_go_r, cmp_go_r;

    wire cs_n_s = cs_sync_r[1];
    wire sck_s = sck_sync_r[1];
    wire si_s = si_sync_r[1];
    wire sck_rise = sck_s & ~sck_d_r & ~cs_n_s;
    wire sck_fall = ~sck_s & sck_d_r & ~cs_n_s;
    wire cs_rise = cs_n_s & ~cs_d_r;
    wire cs_fall = ~cs_n_s & cs_d_r;
    wire [7:0] opcode = shift_r[31:24];
    wire [7:0] opcode_now = {shift_r[6:0], si_s};
    wire has_addr = (nbits_r == 6'd32);
    wire has_op = (nbits_r == 6'd8);
    wire idle = (state_r == srb_pkg::DEV_IDLE);
    wire done = (cnt_r == 16'h0001);
    wire any_susp = ps1_r | ps2_r | es_r;

    // A buffer that holds a suspended program must not be overwritten or used.
    function automatic logic buf_blocked(input logic b, input logic p1, input logic p2);
        buf_blocked = b ? p2 : p1;
    endfunction

    wire is_xfer = (opcode == `SRB_OP_XFER_BUF1) || (opcode == `SRB_OP_XFER_BUF2);
    wire is_cmp = (opcode == `SRB_OP_CMP_BUF1) || (opcode == `SRB_OP_CMP_BUF2);
    wire op_buf = (opcode == `SRB_OP_XFER_BUF2) || (opcode == `SRB_OP_CMP_BUF2);
    // The opcode sits in the top byte only after all 32 bits; after 8 bits it is the low byte.
    wire [7:0] short_op = shift_r[7:0];
    wire do_xfer = cs_rise & has_addr & is_xfer & idle & ~buf_blocked(op_buf, ps1_r, ps2_r);
    wire do_cmp = cs_rise & has_addr & is_cmp & idle & ~buf_blocked(op_buf, ps1_r, ps2_r);
    wire do_resume = cs_rise & has_op & (short_op == `SRB_OP_RESUME) & idle & any_susp;
    wire do_suspend = cs_rise & has_op & (short_op == `SRB_OP_SUSPEND)
        & ((state_r == srb_pkg::DEV_PROG) | (state_r == srb_pkg::DEV_ERASE));
    wire take_prog = prog_start & idle & ~ps1_r & ~ps2_r;
    wire take_erase = erase_start & idle & ~any_susp;

    wire [7:0] status_now;
    assign status_now[`SRB_ST_READY_BIT] = idle;
    assign status_now[`SRB_ST_CMP_BIT] = cmp_fail_r;
    assign status_now[5:3] = 3'h0;
    assign status_now[`SRB_ST_ES_BIT] = es_r;
    assign status_now[`SRB_ST_PS2_BIT] = ps2_r;
    assign status_now[`SRB_ST_PS1_BIT] = ps1_r;

    // Link pins come from another clock domain.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cs_sync_r <= 2'h3;
            sck_sync_r <= 2'h0;
            si_sync_r <= 2'h0;
            cs_d_r <= 1'b1;
            sck_d_r <= 1'b0;
        end else begin
            cs_sync_r <= {cs_sync_r[0], link.cs_n};
            sck_sync_r <= {sck_sync_r[0], link.sck};
            si_sync_r <= {si_sync_r[0], link.si};
            cs_d_r <= cs_n_s;
            sck_d_r <= sck_s;
        end
    end

    // Command shifter; a status read answers from the bit after the opcode.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shift_r <= 32'h0000_0000;
            nbits_r <= 6'h00;
            out_r <= 8'h00;
        end else if (cs_fall) begin
            nbits_r <= 6'h00;
        end else if (sck_rise) begin
            shift_r <= {shift_r[30:0], si_s};
            if (nbits_r != 6'h3f) begin
                nbits_r <= nbits_r + 6'h01;
            end
            if (nbits_r == 6'd7 && opcode_now == `SRB_OP_STATUS) begin
                out_r <= status_now;
            end
        end else if (sck_fall && nbits_r > 6'd8) begin
            out_r <= {out_r[6:0], 1'b0};
        end
    end

    // Operation sequencer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= srb_pkg::DEV_IDLE;
            cnt_r <= 16'h0000;
            prog_left_r <= 16'h0000;
            erase_left_r <= 16'h0000;
            ps1_r <= 1'b0;
            ps2_r <= 1'b0;
            es_r <= 1'b0;
            prog_buf_r <= 1'b0;
            res_prog_r <= 1'b0;
            cmp_fail_r <= 1'b0;
            page_addr_r <= 24'h00_0000;
            sel_buf_r <= 1'b0;
            xfer_go_r <= 1'b0;
            cmp_go_r <= 1'b0;
        end else begin
            xfer_go_r <= 1'b0;
            cmp_go_r <= 1'b0;
            case (state_r)
                srb_pkg::DEV_IDLE: begin
                    if (do_resume) begin
                        state_r <= srb_pkg::DEV_RESUMING;
                        cnt_r <= 16'(`SRB_RESUME_CYC);
                        res_prog_r <= ps1_r | ps2_r;
                    end else if (do_xfer || do_cmp) begin
                        state_r <= do_xfer ? srb_pkg::DEV_XFER : srb_pkg::DEV_CMP;
                        cnt_r <= do_xfer ? 16'(`SRB_COPY_CYC) : 16'(`SRB_COMPARE_CYC);
                        page_addr_r <= shift_r[23:0];
                        sel_buf_r <= op_buf;
                        xfer_go_r <= do_xfer;
                        cmp_go_r <= do_cmp;
                    end else if (take_prog) begin
                        state_r <= srb_pkg::DEV_PROG;
                        cnt_r <= 16'(`SRB_PROGRAM_CYC);
                        prog_buf_r <= prog_buf;
                    end else if (take_erase) begin
                        state_r <= srb_pkg::DEV_ERASE;
                        cnt_r <= 16'(`SRB_ERASE_CYC);
                    end
                end
                srb_pkg::DEV_PROG, srb_pkg::DEV_ERASE: begin
                    if (do_suspend) begin
                        state_r <= srb_pkg::DEV_IDLE;
                        if (state_r == srb_pkg::DEV_PROG) begin
                            prog_left_r <= cnt_r;
                            ps1_r <= ~prog_buf_r;
                            ps2_r <= prog_buf_r;
                        end else begin
                            erase_left_r <= cnt_r;
                            es_r <= 1'b1;
                        end
                    end else if (done) begin
                        state_r <= srb_pkg::DEV_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                srb_pkg::DEV_RESUMING: begin
                    // Suspend commands fall on the floor here, so the host must wait or poll.
                    if (done) begin
                        if (res_prog_r) begin
                            state_r <= srb_pkg::DEV_PROG;
                            cnt_r <= prog_left_r;
                            ps1_r <= 1'b0;
                            ps2_r <= 1'b0;
                        end else begin
                            state_r <= srb_pkg::DEV_ERASE;
                            cnt_r <= erase_left_r;
                            es_r <= 1'b0;
                        end
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                srb_pkg::DEV_XFER, srb_pkg::DEV_CMP: begin
                    if (done) begin
                        state_r <= srb_pkg::DEV_IDLE;
                        if (state_r == srb_pkg::DEV_CMP) begin
                            cmp_fail_r <= page_differs;
                        end
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                default: begin
                    state_r <= srb_pkg::DEV_IDLE;
                end
            endcase
        end
    end

    assign link.so = out_r[7];
    assign page_addr = page_addr_r;
    assign sel_buf = sel_buf_r;
    assign xfer_go = xfer_go_r;
    assign cmp_go = cmp_go_r;
    assign busy = ~idle;
    assign status = status_now;
endmodule
`default_nettype wire

// ===== hw/srb_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "srb_defines.svh"

module srb_host (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt.
    output logic irq,
    // Serial link.
    srb_link_if.host link
);
    srb_pkg::srb_host_state_e state_r;
    logic [7:0] op_r, rx_r;
    logic [23:0] addr_r;
    logic [31:0] tx_r;
    logic [5:0] bits_left_r;
    logic [7:0] div_r;
    logic cs_n_r, sck_r, int_done_r, int_mask_r;
    logic [1:0] so_sync_r;

    // Number of bits each opcode needs on the link, reply included.
    function automatic logic [5:0] frame_bits(input logic [7:0] op);
        if (op == `SRB_OP_XFER_BUF1 || op == `SRB_OP_XFER_BUF2 ||
            op == `SRB_OP_CMP_BUF1 || op == `SRB_OP_CMP_BUF2) begin
            frame_bits = 6'd32;
        end else if (op == `SRB_OP_STATUS) begin
            frame_bits = 6'd16;
        end else begin
            frame_bits = 6'd8;
        end
    endfunction

    wire access = psel & penable;
    wire wr = access & pwrite;
    wire sel_cmd = (paddr == `SRB_REG_CMD);
    wire sel_addr = (paddr == `SRB_REG_ADDR);
    wire sel_stat = (paddr == `SRB_REG_STAT);
    wire sel_ist = (paddr == `SRB_REG_INT_STATUS);
    wire sel_imask = (paddr == `SRB_REG_INT_MASK);
    wire mapped = sel_cmd | sel_addr | sel_stat | sel_ist | sel_imask;
    wire active = (state_r != srb_pkg::HST_IDLE);
    wire start = wr & sel_cmd & ~active;
    wire half = (div_r == 8'(`SRB_SCK_HALF_CYC - 1));
    wire frame_done = (state_r == srb_pkg::HST_GAP) & half;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            so_sync_r <= 2'h0;
        end else begin
            so_sync_r <= {so_sync_r[0], link.so};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_r <= 8'h00;
            addr_r <= 24'h00_0000;
            int_mask_r <= 1'(`SRB_INT_MASK_RST);
            int_done_r <= 1'b0;
        end else begin
            if (start) begin
                op_r <= pwdata[7:0];
            end
            if (wr && sel_addr) begin
                addr_r <= pwdata[23:0];
            end
            if (wr && sel_imask) begin
                int_mask_r <= pwdata[`SRB_INT_DONE_BIT];
            end
            // A completion in the clearing cycle keeps the flag set.
            if (frame_done) begin
                int_done_r <= 1'b1;
            end else if (wr && sel_ist && pwdata[`SRB_INT_DONE_BIT]) begin
                int_done_r <= 1'b0;
            end
        end
    end

    // Link sequencer: mode 0, data changes after a falling edge.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= srb_pkg::HST_IDLE;
            tx_r <= 32'h0000_0000;
            rx_r <= 8'h00;
            bits_left_r <= 6'h00;
            div_r <= 8'h00;
            cs_n_r <= 1'b1;
            sck_r <= 1'b0;
        end else begin
            div_r <= (half || state_r == srb_pkg::HST_IDLE) ? 8'h00 : div_r + 8'h01;
            case (state_r)
                srb_pkg::HST_IDLE: begin
                    if (start) begin
                        state_r <= srb_pkg::HST_SETUP;
                        tx_r <= {pwdata[7:0], addr_r};
                        bits_left_r <= frame_bits(pwdata[7:0]);
                        cs_n_r <= 1'b0;
                    end
                end
                srb_pkg::HST_SETUP: begin
                    if (half) begin
                        state_r <= srb_pkg::HST_SHIFT;
                        sck_r <= 1'b1;
                    end
                end
                srb_pkg::HST_SHIFT: begin
                    if (half) begin
                        sck_r <= ~sck_r;
                        if (sck_r) begin
                            tx_r <= {tx_r[30:0], 1'b0};
                            bits_left_r <= bits_left_r - 6'h01;
                            if (bits_left_r == 6'h01) begin
                                state_r <= srb_pkg::HST_GAP;
                            end
                        end
                    end else if (sck_r && div_r == 8'h00) begin
                        // One sample per bit, taken a cycle after the rise while the reply bit is settled.
                        rx_r <= {rx_r[6:0], so_sync_r[1]};
                    end
                end
                srb_pkg::HST_GAP: begin
                    cs_n_r <= 1'b1;
                    if (half) begin
                        state_r <= srb_pkg::HST_IDLE;
                    end
                end
                default: begin
                    state_r <= srb_pkg::HST_IDLE;
                end
            endcase
        end
    end

    wire [31:0] rd_cmd = {24'h00_0000, op_r};
    wire [31:0] rd_addr = {8'h00, addr_r};
    wire [31:0] rd_stat = {16'h0000, rx_r, 7'h00, active};
    wire [31:0] rd_int = {31'h0000_0000, int_done_r};
    wire [31:0] rd_mask = {31'h0000_0000, int_mask_r};
    assign prdata = sel_cmd ? rd_cmd : sel_addr ? rd_addr : sel_stat ? rd_stat :
        sel_ist ? rd_int : sel_imask ? rd_mask : 32'h0000_0000;
    assign pready = 1'b1;
    assign pslverr = access & ~mapped;
    assign irq = int_done_r & int_mask_r;
    assign link.cs_n = cs_n_r;
    assign link.sck = sck_r;
    assign link.si = tx_r[31];
endmodule
`default_nettype wire

// ===== tb/srb_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module srb_assertions (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Serial link.
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    // Device side.
    input wire logic busy,
    input wire logic [7:0] status,
    input wire logic xfer_go,
    input wire logic cmp_go,
    input wire logic sel_buf
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // A launch must follow the close of a frame that has been open for a while.
    sequence s_frame_closed;
        cs_n && !$past(cs_n, 10);
    endsequence
    sequence s_long_busy;
        ##1 busy [*8] ##182 busy;
    endsequence
    sequence s_just_idle;
        !busy && ($past(busy) || $past(busy, 2));
    endsequence

    AST_SCK_IDLE: assert property (cs_n |-> !sck)
        else $error("serial clock moves outside a frame");
    AST_SI_SETUP: assert property ($changed(si) |-> !sck)
        else $error("serial data changed while clock high");
    AST_XFER_LAUNCH: assert property (xfer_go |-> s_frame_closed)
        else $error("copy launched outside frame close");
    AST_XFER_BUSY: assert property (xfer_go |-> s_long_busy)
        else $error("busy dropped during page copy");
    AST_XFER_END: assert property (xfer_go |-> ##[195:215] !busy)
        else $error("page copy did not end in time");
    AST_CMP_BUSY: assert property (cmp_go |-> s_frame_closed and s_long_busy)
        else $error("compare launch or busy wrong");
    AST_CMP_RESULT: assert property ($changed(status[6]) |-> s_just_idle)
        else $error("compare bit changed outside compare end");
    AST_READY_FLAG: assert property (status[7] != busy)
        else $error("ready bit disagrees with busy");
    AST_GUARD: assert property ((xfer_go || cmp_go) |-> !(sel_buf ? status[1] : status[0]))
        else $error("operation on a program-suspended buffer");
    AST_RESUME_BUSY: assert property ($fell(status[0]) || $fell(status[1]) |-> busy)
        else $error("suspend flag cleared without busy");
    AST_PROG_FIRST: assert property (($fell(status[0]) || $fell(status[1])) && $past(status[2]) |-> status[2])
        else $error("erase resumed together with program");
endmodule
`default_nettype wire

// ===== tb/suspend_resume_buffer_xfer_compare_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "srb_defines.svh"
module suspend_resume_buffer_xfer_compare_test;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic prog_start;
    logic prog_buf;
    logic erase_start;
    logic page_differs;
    logic [23:0] page_addr;
    logic sel_buf;
    logic xfer_go;
    logic cmp_go;
    logic busy;
    logic [7:0] status;
    logic [31:0] rd;
    logic err;
    logic [25:0] head;
    logic [25:0] exp_q[$];
    logic [7:0] ops [4];
    int error_cnt;
    int check_count;
    int ps1;
    int ps2;
    int es;
    int cres;
    int mask_m;
    int running;
    int seed;

    srb_link_if link();
    srb_dev u_srb_dev (.pclk(pclk), .presetn(presetn), .link(link), .prog_start(prog_start),
        .prog_buf(prog_buf), .erase_start(erase_start), .page_differs(page_differs),
        .page_addr(page_addr), .sel_buf(sel_buf), .xfer_go(xfer_go), .cmp_go(cmp_go),
        .busy(busy), .status(status));
    srb_host u_srb_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .link(link));
    srb_assertions u_srb_assertions (.pclk(pclk), .presetn(presetn), .cs_n(link.cs_n),
        .sck(link.sck), .si(link.si), .busy(busy), .status(status), .xfer_go(xfer_go),
        .cmp_go(cmp_go), .sel_buf(sel_buf));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic fail(input string m);
        error_cnt++;
        $display("wrong value at %0t: %s", $time, m);
    endtask

    task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp) begin
            fail(m);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // The model decides up front which launches must appear, so a wrong launch is caught by the monitor.
    task automatic send(input logic [7:0] op, input logic [23:0] a, input logic d);
        logic sel;
        sel = (op == `SRB_OP_XFER_BUF2) || (op == `SRB_OP_CMP_BUF2);
        if ((op == `SRB_OP_XFER_BUF1 || op == `SRB_OP_XFER_BUF2) && (sel ? ps2 : ps1) == 0) begin
            exp_q.push_back({1'b0, sel, a});
        end
        if ((op == `SRB_OP_CMP_BUF1 || op == `SRB_OP_CMP_BUF2) && (sel ? ps2 : ps1) == 0) begin
            exp_q.push_back({1'b1, sel, a});
            cres = d;
        end
        apb(1'b1, `SRB_REG_ADDR, {8'h00, a});
        page_differs <= d;
        apb(1'b0, `SRB_REG_ADDR, 32'h0);
        expect_eq(rd, {8'h00, a}, "address readback");
        apb(1'b1, `SRB_REG_CMD, {24'h000000, op});
        apb(1'b0, `SRB_REG_STAT, 32'h0);
        expect_eq(rd[0], 1'b1, "frame in progress");
        do begin
            apb(1'b0, `SRB_REG_INT_STATUS, 32'h0);
        end while (rd[0] !== 1'b1);
        expect_eq(irq, mask_m[0], "interrupt level");
        apb(1'b1, `SRB_REG_INT_STATUS, 32'h1);
        @(negedge pclk);
        expect_eq(irq, 1'b0, "interrupt after clear");
        if (op == `SRB_OP_RESUME) begin
            es = (ps1 + ps2 > 0) ? es : 0;
            ps1 = 0;
            ps2 = 0;
        end
        if (op == `SRB_OP_SUSPEND) begin
            ps1 = ps1 | (running == 1);
            ps2 = ps2 | (running == 2);
            es = es | (running == 3);
            running = 0;
        end
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 4000) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 4000) begin
            fail("device stayed busy");
        end
        @(negedge pclk);
    endtask

    task automatic check_stat();
        logic [7:0] exp;
        exp = {1'b1, cres[0], 3'b000, es[0], ps2[0], ps1[0]};
        send(`SRB_OP_STATUS, 24'h000000, 1'b0);
        apb(1'b0, `SRB_REG_STAT, 32'h0);
        expect_eq(rd[15:8], exp, "status over link");
        expect_eq(status, exp, "status port");
    endtask

    task automatic resume_check();
        send(`SRB_OP_RESUME, 24'h000000, 1'b0);
        repeat (`SRB_RESUME_CYC + 10) @(posedge pclk);
        expect_eq({busy, status[7], status[2:0]}, {1'b1, 1'b0, es[0], ps2[0], ps1[0]}, "resumed");
        wait_idle();
    endtask

    // Kind 1 and 2 program a buffer, kind 3 erases.
    task automatic start_op(input int kind);
        @(posedge pclk);
        prog_buf <= (kind == 2);
        prog_start <= (kind != 3);
        erase_start <= (kind == 3);
        @(posedge pclk);
        prog_start <= 1'b0;
        erase_start <= 1'b0;
        running = kind;
        repeat (20) @(posedge pclk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(negedge pclk) begin
        if (xfer_go === 1'b1 || cmp_go === 1'b1) begin
            if (exp_q.size() == 0) begin
                fail("unexpected launch");
            end else begin
                head = exp_q.pop_front();
                expect_eq({cmp_go, sel_buf, page_addr}, head, "launch");
            end
        end
    end

    initial begin
        repeat (90000) @(posedge pclk);
        fail("run too long");
        tally_and_finish();
    end

    initial begin
        seed = $urandom(32'h68f7);
        ops = '{`SRB_OP_XFER_BUF1, `SRB_OP_XFER_BUF2, `SRB_OP_CMP_BUF1, `SRB_OP_CMP_BUF2};
        {presetn, psel, penable, pwrite, prog_start, prog_buf, erase_start, page_differs} = 8'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        {error_cnt, check_count, ps1, ps2, es, cres, mask_m, running} = '0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        expect_eq(status, 8'h80, "status after reset");
        apb(1'b0, `SRB_REG_INT_MASK, 32'h0);
        expect_eq(rd, `SRB_INT_MASK_RST, "mask reset");
        apb(1'b0, 12'h020, 32'h0);
        expect_eq(err, 1'b1, "unmapped error");
        apb(1'b1, `SRB_REG_INT_MASK, 32'h1);
        mask_m = 1;
        for (int i = 0; i < 8; i++) begin
            send(ops[i % 4], 24'($urandom()), i[0] ^ i[2]);
            wait_idle();
            check_stat();
        end
        // A masked event must still latch but keep the line low.
        apb(1'b1, `SRB_REG_INT_MASK, 32'h0);
        mask_m = 0;
        check_stat();
        apb(1'b1, `SRB_REG_INT_MASK, 32'h1);
        mask_m = 1;
        start_op(1);
        send(`SRB_OP_SUSPEND, 24'h000000, 1'b0);
        check_stat();
        for (int i = 0; i < 4; i++) begin
            send(ops[i], 24'($urandom()), ~i[1]);
            wait_idle();
        end
        check_stat();
        resume_check();
        check_stat();
        start_op(3);
        send(`SRB_OP_SUSPEND, 24'h000000, 1'b0);
        send(`SRB_OP_XFER_BUF1, 24'($urandom()), 1'b0);
        wait_idle();
        start_op(2);
        send(`SRB_OP_SUSPEND, 24'h000000, 1'b0);
        check_stat();
        resume_check();
        check_stat();
        resume_check();
        check_stat();
        expect_eq(exp_q.size(), 0, "launches missing");
        tally_and_finish();
    end
endmodule
`default_nettype wire
